// ===== rtl/port_io_pkg.sv
// Constants, register map and carrier types for the port I/O block
package port_io_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GROUP_LEVEL = 8'hE0;
  localparam logic [7:0] IDX_EXTRA_LEVEL = 8'hE1;
  localparam logic [7:0] IDX_GROUP_EDGE = 8'hE5;
  localparam logic [7:0] IDX_EXTRA_EDGE = 8'hE6;
  localparam logic [7:0] IDX_GROUP_IRQ_EN = 8'hE8;
  localparam logic [7:0] IDX_EXTRA_IRQ_EN = 8'hE9;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'hED;
  localparam logic [7:0] IDX_OUT_A = 8'hF3;
  localparam logic [7:0] IDX_OUT_B = 8'hF4;
  localparam logic [7:0] IDX_BIDIR_DATA = 8'hF6;
  localparam logic [7:0] IDX_BIDIR_DIR = 8'hFC;

  localparam int APB_ADDR_W = 12;

  // Field positions
  localparam int FLAG_GROUP_BIT = 0;
  localparam int FLAG_EXTRA_BIT = 1;
  localparam int OUT_B_CLK_BIT = 0;
  localparam int OUT_B_TONE_BIT = 2;

  // Reset values
  localparam logic [3:0] RST_EDGE = 4'h0;
  localparam logic [3:0] RST_IRQ_EN = 4'h0;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [3:0] RST_OUT_A = 4'h0;
  localparam logic [2:0] RST_OUT_B = 3'h0;
  localparam logic [3:0] RST_BIDIR_DATA = 4'h0;
  localparam logic RST_BIDIR_DIR = 1'b0;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILTER_TIME_NS = 500000;
  localparam int FILTER_CYCLES_DEF = FILTER_TIME_NS / CLK_PERIOD_NS;
  localparam int CLK_DIV_DEF = 1;

  // Special-output choices for output b bit2
  typedef enum logic [1:0] {
    TONE_PLAIN = 2'b00,
    TONE_INVERTED = 2'b01,
    TONE_ENVELOPE = 2'b11
  } tone_mode_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } bidir_drive_t;

  typedef struct packed {
    logic [3:0] group_a;
    logic [2:0] group_b;
  } out_pins_t;

endpackage

// ===== rtl/port_io_with_edge_irq.sv
// Port I/O block: edge interrupt inputs, output ports, bidir port, APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module port_io_with_edge_irq
  import port_io_pkg::*;
#(
  parameter int CLK_DIV = CLK_DIV_DEF,
  parameter bit CLK_OUT_EN = 1'b0,
  parameter tone_mode_t TONE_MODE = TONE_PLAIN,
  parameter bit FILTER_EN = 1'b0,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input pins
  input wire logic [3:0] input_group_pins,
  input wire logic extra_input_pin,
  // Tone from melody generator
  input wire logic tone_in,
  // Output pins
  output out_pins_t out_pins,
  // Bidirectional port
  input wire logic [3:0] bidir_port_pins_in,
  output bidir_drive_t bidir_drive,
  output logic bidir_pull_down,
  // Interrupt events to the CPU
  output logic group_irq_flag,
  output logic extra_irq_flag
);

  localparam int DIV_BIT = (CLK_DIV > 1) ? $clog2(CLK_DIV) - 1 : 0;
  localparam int FCNT_W = $clog2(FILTER_CYCLES + 1);

  // Elaboration checks: the tap select and filter counter serve no other values
  if (CLK_DIV < 1 || CLK_DIV > 128 || (CLK_DIV & (CLK_DIV - 1)) != 0) begin : g_bad_div
    $error("CLK_DIV must be a power of two from 1 to 128");
  end
  if (FILTER_CYCLES < 1) begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] group_edge_select;
  logic extra_edge_select;
  logic [3:0] group_irq_enable;
  logic extra_irq_enable;
  logic [3:0] output_group_a;
  logic [2:0] output_b;
  logic [3:0] bidir_data;
  logic bidir_direction_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronizers; first stage feeds only the second
  logic [8:0] sync1;
  logic [8:0] sync2;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= {bidir_port_pins_in, extra_input_pin, input_group_pins};
      sync2 <= sync1;
    end
  end

  logic [3:0] group_lvl;
  logic extra_lvl;
  logic [3:0] bidir_lvl;
  assign group_lvl = sync2[3:0];
  assign extra_lvl = sync2[4];
  assign bidir_lvl = sync2[8:5];

  ////////////////////////////////////////////////////////////////////////////
  // Match detection: masked pins always count as matching
  logic [1:0] raw_match;
  assign raw_match[0] = &(~group_irq_enable | ~(group_lvl ^ group_edge_select));
  assign raw_match[1] = ~extra_irq_enable | ~(extra_lvl ^ extra_edge_select);

  logic [1:0] match;
  logic [1:0] match_prev;
  logic [1:0] irq_event;

  // Noise filter per pin series: match must hold FILTER_CYCLES before it counts
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filter
      if (FILTER_EN) begin : g_on
        logic [FCNT_W-1:0] cnt;
        logic stable;
        always_ff @(posedge ref_clk) begin
          if (srst) begin
            cnt <= '0;
            stable <= 1'b1;
          end else if (raw_match[g] == stable) begin
            cnt <= '0;
          end else if (cnt == FCNT_W'(FILTER_CYCLES - 1)) begin
            cnt <= '0;
            stable <= raw_match[g];
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        assign match[g] = stable;
      end else begin : g_off
        assign match[g] = raw_match[g];
      end
    end
  endgenerate

  // Reset to matching, so leaving reset raises no event
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      match_prev <= 2'b11;
    end else begin
      match_prev <= match;
    end
  end

  // Only the matching to non-matching step fires
  assign irq_event = match_prev & ~match;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic setup;
  logic access;
  logic [9:0] word;
  logic wr_go;
  logic rd_go;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign word = paddr[APB_ADDR_W-1:2];
  assign wr_go = access & pwrite;
  assign rd_go = access & ~pwrite;

  function automatic logic hit(input logic [9:0] w, input logic [7:0] idx);
    hit = (w == {2'b00, idx});
  endfunction

  logic [1:0] irq_flags;

  ////////////////////////////////////////////////////////////////////////////
  // Edge selects: 1 picks the falling edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      group_edge_select <= RST_EDGE;
      extra_edge_select <= RST_EDGE[0];
    end else if (wr_go) begin
      if (hit(word, IDX_GROUP_EDGE)) begin
        group_edge_select <= pwdata[3:0];
      end
      if (hit(word, IDX_EXTRA_EDGE)) begin
        extra_edge_select <= pwdata[0];
      end
    end
  end

  // Enabling a pin whose level already differs fires at once
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      group_irq_enable <= RST_IRQ_EN;
      extra_irq_enable <= RST_IRQ_EN[0];
    end else if (wr_go) begin
      if (hit(word, IDX_GROUP_IRQ_EN)) begin
        group_irq_enable <= pwdata[3:0];
      end
      if (hit(word, IDX_EXTRA_IRQ_EN)) begin
        extra_irq_enable <= pwdata[0];
      end
    end
  end

  // Factor flags: a new event in the clearing read's cycle survives
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_flags <= RST_FLAGS;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (irq_event[i]) begin
          irq_flags[i] <= 1'b1;
        end else if (rd_go && hit(word, IDX_IRQ_FLAGS)) begin
          irq_flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      group_irq_flag <= 1'b0;
      extra_irq_flag <= 1'b0;
    end else begin
      group_irq_flag <= irq_flags[FLAG_GROUP_BIT];
      extra_irq_flag <= irq_flags[FLAG_EXTRA_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      output_group_a <= RST_OUT_A;
      output_b <= RST_OUT_B;
    end else if (wr_go) begin
      if (hit(word, IDX_OUT_A)) begin
        output_group_a <= pwdata[3:0];
      end
      if (hit(word, IDX_OUT_B)) begin
        output_b <= pwdata[2:0];
      end
    end
  end

  // Bidir data accepted in either direction; reads return the pins, not this
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bidir_data <= RST_BIDIR_DATA;
      bidir_direction_bit <= RST_BIDIR_DIR;
    end else if (wr_go) begin
      if (hit(word, IDX_BIDIR_DATA)) begin
        bidir_data <= pwdata[3:0];
      end
      if (hit(word, IDX_BIDIR_DIR)) begin
        bidir_direction_bit <= pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divided clock
  logic [6:0] div_cnt;
  logic div_tap;

  // Free-running; the tap bit alone sets the divide ratio
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  assign div_tap = div_cnt[DIV_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  logic pin_b0;
  logic pin_b2;
  logic pin_b0_out;
  logic [3:0] pin_a;
  logic pin_b1;

  // Plain output pins, one flop each
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_a <= '0;
      pin_b1 <= 1'b0;
    end else begin
      pin_a <= output_group_a;
      pin_b1 <= output_b[1];
    end
  end

  // Special-output pins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_b0 <= 1'b0;
      pin_b2 <= 1'b0;
    end else begin
      // Gating is synchronous, so on/off does not glitch except at divide 1
      if (CLK_OUT_EN && CLK_DIV > 1) begin
        pin_b0 <= output_b[OUT_B_CLK_BIT] & div_tap;
      end else begin
        pin_b0 <= output_b[OUT_B_CLK_BIT];
      end
      case (TONE_MODE)
        TONE_INVERTED: pin_b2 <= ~tone_in;
        TONE_ENVELOPE: pin_b2 <= tone_in;
        default: pin_b2 <= output_b[OUT_B_TONE_BIT];
      endcase
    end
  end

  // Bidir drivers; the direction fans out to every pin at once
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bidir_drive <= '0;
    end else begin
      bidir_drive.out <= bidir_data;
      bidir_drive.oe <= {4{bidir_direction_bit}};
    end
  end

  // Divide by one needs the raw clock, which no flop can produce
  generate
    if (CLK_OUT_EN && CLK_DIV == 1) begin : g_div1
      logic gate_q;
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          gate_q <= 1'b0;
        end else begin
          gate_q <= output_b[OUT_B_CLK_BIT];
        end
      end
      assign pin_b0_out = gate_q & ref_clk;
    end else begin : g_divn
      assign pin_b0_out = pin_b0;
    end
  endgenerate

  assign out_pins = {pin_a, pin_b2, pin_b1, pin_b0_out};

  ////////////////////////////////////////////////////////////////////////////
  // Pull-down for one clock, during the access cycle of an input-mode read
  // Read data is latched at setup, so the pull cannot disturb it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bidir_pull_down <= 1'b0;
    end else begin
      bidir_pull_down <= setup & ~pwrite & hit(word, IDX_BIDIR_DATA) & ~bidir_direction_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and response, zero wait states
  // Writes answer zero data; unmapped words answer an error
  logic [31:0] next_prdata;
  logic next_err;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (word)
      {2'b00, IDX_GROUP_LEVEL}: next_prdata[3:0] = group_lvl;
      {2'b00, IDX_EXTRA_LEVEL}: next_prdata[0] = extra_lvl;
      {2'b00, IDX_GROUP_EDGE}: next_prdata[3:0] = group_edge_select;
      {2'b00, IDX_EXTRA_EDGE}: next_prdata[0] = extra_edge_select;
      {2'b00, IDX_GROUP_IRQ_EN}: next_prdata[3:0] = group_irq_enable;
      {2'b00, IDX_EXTRA_IRQ_EN}: next_prdata[0] = extra_irq_enable;
      {2'b00, IDX_IRQ_FLAGS}: next_prdata[1:0] = irq_flags;
      {2'b00, IDX_OUT_A}: next_prdata[3:0] = output_group_a;
      {2'b00, IDX_OUT_B}: next_prdata[2:0] = output_b;
      {2'b00, IDX_BIDIR_DATA}: next_prdata[3:0] = bidir_lvl;
      {2'b00, IDX_BIDIR_DIR}: next_prdata[0] = bidir_direction_bit;
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_err;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // port_io_with_edge_irq

// ===== sim/port_io_sva.sv
// Port-level checks for the port I/O block
`timescale 1ns/100ps
module port_io_sva
  import port_io_pkg::*;
#(
  parameter tone_mode_t TONE_MODE = TONE_PLAIN
) (
  // Clock, reset, bus
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and events
  input wire logic tone_in,
  input wire out_pins_t out_pins,
  input wire bidir_drive_t bidir_drive,
  input wire logic bidir_pull_down,
  input wire logic group_irq_flag,
  input wire logic extra_irq_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready && $past(paddr) == paddr)
    else $error("no answer after setup");
  a_upper_bits_zero: assert property (pready |-> prdata[31:4] == 28'h0)
    else $error("unused read bits set");
  a_pull_on_read: assert property (psel && !penable && !pwrite && paddr == 12'h3D8
    |=> bidir_pull_down == (bidir_drive.oe == 4'h0)) else $error("pull-down wrong on read");
  a_pull_only_read: assert property (bidir_pull_down |-> psel && penable && !pwrite
    && paddr == 12'h3D8) else $error("pull-down outside read");
  a_dir_all_bits: assert property (bidir_drive.oe == 4'h0 || bidir_drive.oe == 4'hF)
    else $error("direction split");
  a_reset_outputs: assert property ($fell(srst) |-> out_pins == 7'h0
    && bidir_drive.oe == 4'h0 && !group_irq_flag && !extra_irq_flag)
    else $error("outputs not cleared by reset");
  a_out_a_write: assert property (psel && penable && pwrite && pready && paddr == 12'h3CC
    |=> ##1 out_pins.group_a == $past(pwdata[3:0], 2)) else $error("group a pins wrong");
  a_bidir_write: assert property (psel && penable && pwrite && pready && paddr == 12'h3D8
    |=> ##1 bidir_drive.out == $past(pwdata[3:0], 2)) else $error("bidir data wrong");
  a_tone_pin: assert property (TONE_MODE == TONE_INVERTED
    |=> out_pins.group_b[2] == !$past(tone_in)) else $error("tone pin wrong");
endmodule // port_io_sva

bind port_io_with_edge_irq port_io_sva #(.TONE_MODE(TONE_MODE)) i_port_io_sva (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .tone_in(tone_in),
  .out_pins(out_pins), .bidir_drive(bidir_drive), .bidir_pull_down(bidir_pull_down),
  .group_irq_flag(group_irq_flag), .extra_irq_flag(extra_irq_flag));

// ===== sim/ext_pins.sv
// Outside world of the port block: keys and a part on the bidir port
`timescale 1ns/100ps
module ext_pins
  import port_io_pkg::*;
(
  // Levels the scenario sets outside
  input wire logic [3:0] key_level,
  input wire logic key_extra,
  input wire logic [3:0] far_level,
  input wire logic far_drives,
  // Block side
  input wire bidir_drive_t bidir_drive,
  input wire logic bidir_pull_down,
  output logic [3:0] input_group_pins,
  output logic extra_input_pin,
  output logic [3:0] bidir_port_pins_in
);
  assign input_group_pins = key_level;
  assign extra_input_pin = key_extra;
  // Undriven line floats: inverse of last drive, so no lucky zero
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (bidir_drive.oe[i]) bidir_port_pins_in[i] = bidir_drive.out[i];
      else if (far_drives) bidir_port_pins_in[i] = far_level[i];
      else if (bidir_pull_down) bidir_port_pins_in[i] = 1'b0;
      else bidir_port_pins_in[i] = !bidir_drive.out[i];
    end
  end
endmodule // ext_pins

// ===== sim/port_io_with_edge_irq_bench.sv
// Self-checking bench for the port I/O block
`timescale 1ns/100ps
module port_io_with_edge_irq_bench;
  import port_io_pkg::*;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
  logic ref_clk, srst, psel, penable, pwrite, tone_in, key_extra, far_drives, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, group_irq_flag, extra_irq_flag, bidir_pull_down;
  logic [3:0] key_level, far_level, group_pins, bidir_in, v;
  logic extra_pin;
  out_pins_t out_pins;
  bidir_drive_t bidir_drive;
  int bad_count, checks_done, n;
  logic [7:0] rw_idx [7] = '{8'hE5, 8'hE6, 8'hE8, 8'hE9, 8'hF3, 8'hF4, 8'hFC};
  logic [3:0] rw_msk [7] = '{4'hF, 4'h1, 4'hF, 4'h1, 4'hF, 4'h7, 4'h1};
  logic [3:0] mdl [7];
  port_io_with_edge_irq #(.CLK_DIV(2), .CLK_OUT_EN(1'b1), .TONE_MODE(TONE_INVERTED),
    .FILTER_EN(1'b0), .FILTER_CYCLES(8)) i_port_io_with_edge_irq (.ref_clk(ref_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_group_pins(group_pins), .extra_input_pin(extra_pin), .tone_in(tone_in),
    .out_pins(out_pins), .bidir_port_pins_in(bidir_in), .bidir_drive(bidir_drive),
    .bidir_pull_down(bidir_pull_down), .group_irq_flag(group_irq_flag),
    .extra_irq_flag(extra_irq_flag));
  ext_pins i_ext_pins (.key_level(key_level), .key_extra(key_extra), .far_level(far_level),
    .far_drives(far_drives), .bidir_drive(bidir_drive), .bidir_pull_down(bidir_pull_down),
    .input_group_pins(group_pins), .extra_input_pin(extra_pin), .bidir_port_pins_in(bidir_in));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tone_in <= 1'($urandom);
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; answer taken at the edge that sees pready
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [3:0] wd);
    int k;
    k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00}; pwdata <= {28'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) begin bad_count++; end_sim(); end
      @(posedge ref_clk);
    end
    rdata = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge, so the next call never re-drives psel in the same step
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [3:0] e);
    xfer(1'b0, idx, 4'h0);
    `CHK(rdata, {28'h0, e})
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 12'h0; pwdata = 0;
    key_level = 0; key_extra = 0; far_level = 0; far_drives = 1;
    bad_count = 0; checks_done = 0;
    void'($urandom(16));
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) rd_chk(rw_idx[i], 4'h0);
    rd_chk(8'hED, 4'h0);
    far_drives <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 7; i++) begin
        v = 4'($urandom);
        xfer(1'b1, rw_idx[i], v);
        mdl[i] = v & rw_msk[i];
      end
      for (int i = 0; i < 7; i++) rd_chk(rw_idx[i], mdl[i]);
      `CHK({out_pins.group_a, out_pins.group_b[1]}, {mdl[4], mdl[5][1]})
    end
    xfer(1'b1, 8'hE0, 4'hF); rd_chk(8'hE0, 4'h0);
    xfer(1'b1, 8'hFF, 4'hF); `CHK({rerr, rdata}, 33'h100000000)
    for (int r = 0; r < 4; r++) begin
      key_level <= 4'($urandom); key_extra <= 1'($urandom);
      repeat (5) @(posedge ref_clk);
      rd_chk(8'hE0, key_level); rd_chk(8'hE1, {3'b000, key_extra});
    end
    key_level <= 4'h0; key_extra <= 1'b1;
    xfer(1'b1, 8'hE8, 4'h0); xfer(1'b1, 8'hE9, 4'h0);
    xfer(1'b1, 8'hE5, 4'h0); xfer(1'b1, 8'hE6, 4'h1);
    repeat (5) @(posedge ref_clk);
    xfer(1'b1, 8'hED, 4'h0); xfer(1'b0, 8'hED, 4'h0);
    xfer(1'b1, 8'hE8, 4'hE); xfer(1'b1, 8'hE9, 4'h1);
    repeat (6) @(posedge ref_clk);
    rd_chk(8'hED, 4'h0);
    key_level <= 4'h1; repeat (6) @(posedge ref_clk); rd_chk(8'hED, 4'h0);
    key_level <= 4'h9; repeat (6) @(posedge ref_clk);
    `CHK({extra_irq_flag, group_irq_flag}, 2'b01)
    rd_chk(8'hED, 4'h1); rd_chk(8'hED, 4'h0);
    key_level <= 4'hD; repeat (6) @(posedge ref_clk); rd_chk(8'hED, 4'h0);
    key_level <= 4'h0; repeat (6) @(posedge ref_clk); rd_chk(8'hED, 4'h0);
    key_extra <= 1'b0; repeat (6) @(posedge ref_clk); rd_chk(8'hED, 4'h2);
    v = 4'($urandom); far_level <= v; far_drives <= 1'b1;
    xfer(1'b1, 8'hFC, 4'h0); xfer(1'b1, 8'hF6, ~v);
    repeat (5) @(posedge ref_clk);
    rd_chk(8'hF6, v);
    far_drives <= 1'b0;
    xfer(1'b1, 8'hFC, 4'h1); repeat (5) @(posedge ref_clk);
    rd_chk(8'hF6, ~v); `CHK(bidir_drive.oe, 4'hF)
    for (int g = 1; g >= 0; g--) begin
      xfer(1'b1, 8'hF4, 4'(g)); repeat (4) @(posedge ref_clk);
      n = 0;
      repeat (16) begin
        @(negedge ref_clk);
        // An unknown pin level counts heavily so it cannot pass
        n += (out_pins.group_b[0] === 1'b1) ? 1 : ((out_pins.group_b[0] === 1'b0) ? 0 : 100);
      end
      `CHK(n, 8 * g)
    end
    end_sim();
  end
endmodule // port_io_with_edge_irq_bench
